// >>> verilog/host_queue_frame_access.sv
// Purpose: Host access to the transmit and receive queue memories.
// Assumes: Host command port already on clk_sys; big-endian strap is a pin.
// Notes: One stored receive frame and one queued transmit frame at a time.
// Function
// [R1] Receive queue command bit 3 opens the data window.
// [R2] Pointer bit 14 auto-advances the write pointer per data access.
// [R3] Interrupt enable bit 14 gates the transmit-done interrupt.
// [R4] Interrupt enable bit 6 gates the transmit-space-available interrupt.
// [R5] Status bits clear on write of one.
// [R6] Space request counts double words.
// [R7] Stored receive frame starts with a status word at offset 0.
// [R8] Offset 2 of a stored receive frame holds the total byte count.
// [R9] Receive data from offset 4, CRC kept.
// [R10] At most 2000 receive data bytes are stored per frame.
// [R11] Big-endian mode swaps bytes of both header words.
// [R12] Receive control bit 10 enables flow control, bit 0 reception.
// [R13] Transmit command bit 0 queues the frame and self-clears when sent.
// [R14] Transmit command bit 1 arms a space check raising status bit 6.
// [R15] Interrupt request asserted while any enabled status bit is set.
`timescale 1ns/1ps
module host_queue_frame_access #(
    parameter int RX_WORDS = 1024,
    parameter int TX_WORDS = 1024
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Host command port.
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [1:0] bus_be,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic big_endian_pin,
    // Receive stream from the MAC.
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_error,
    // Transmit stream to the MAC.
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [15:0] tx_data,
    output logic tx_last,
    // Status towards the host and MAC.
    output logic irq_n,
    output logic rx_flow_ctrl_en
);
    localparam int RXA = $clog2(RX_WORDS);
    localparam int TXA = $clog2(TX_WORDS);
    localparam logic [16:0] TX_DWORDS = 17'(TX_WORDS / 2);

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_DATA = 5'b00010,
        RX_HDR0 = 5'b00100,
        RX_HDR1 = 5'b01000,
        RX_HOLD = 5'b10000
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_DONE = 3'b100
    } tx_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Registers and memories.
    logic [15:0] rx_control_one_reg;
    logic [15:0] rx_queue_cmd_reg;
    logic [15:0] tx_queue_cmd_reg;
    logic [15:0] tx_data_ptr_reg;
    logic [15:0] int_enable_reg;
    logic [15:0] int_status_reg;
    logic [15:0] tx_space_req_reg;
    logic [15:0] rx_mem [RX_WORDS];
    logic [15:0] tx_mem [TX_WORDS];
    logic be_sync1_reg;
    logic be_sync2_reg;

    // The strap is a pin, so it crosses two flops before anything reads it.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            be_sync1_reg <= 1'b0;
            be_sync2_reg <= 1'b0;
        end else begin
            be_sync1_reg <= big_endian_pin;
            be_sync2_reg <= be_sync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    wire [15:0] be_mask = {{8{bus_be[1]}}, {8{bus_be[0]}}};
    wire sel_txq_cmd = (bus_addr == queue_access_pkg::OFF_TX_QUEUE_CMD);
    wire sel_rxc1 = (bus_addr == queue_access_pkg::OFF_RX_CONTROL_ONE);
    wire sel_rxq_cmd = (bus_addr == queue_access_pkg::OFF_RX_QUEUE_CMD);
    wire sel_txptr = (bus_addr == queue_access_pkg::OFF_TX_DATA_PTR);
    wire sel_ier = (bus_addr == queue_access_pkg::OFF_INT_ENABLE);
    wire sel_isr = (bus_addr == queue_access_pkg::OFF_INT_STATUS);
    wire sel_space = (bus_addr == queue_access_pkg::OFF_TX_SPACE_REQ);
    wire sel_data = (bus_addr == queue_access_pkg::OFF_QUEUE_DATA);
    wire dma_open = rx_queue_cmd_reg[queue_access_pkg::BIT_RXQ_DMA_START];
    wire data_wr = bus_wr && sel_data && dma_open; // [R1]
    wire data_rd = bus_rd && sel_data && dma_open; // [R1]
    wire [15:0] wmerge_rxc1 = (rx_control_one_reg & ~be_mask) | (bus_wdata & be_mask);
    wire [15:0] wmerge_rxq = (rx_queue_cmd_reg & ~be_mask) | (bus_wdata & be_mask);
    wire [15:0] wmerge_ptr = (tx_data_ptr_reg & ~be_mask) | (bus_wdata & be_mask);
    wire [15:0] wmerge_ier = (int_enable_reg & ~be_mask) | (bus_wdata & be_mask);
    wire [15:0] wmerge_space = (tx_space_req_reg & ~be_mask) | (bus_wdata & be_mask);
    wire [15:0] isr_clear = (bus_wr && sel_isr) ? (bus_wdata & be_mask) : 16'h0000;
    wire [15:0] txq_set = (bus_wr && sel_txq_cmd) ? (bus_wdata & be_mask) : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Receive path: FIFO then frame writer.
    logic fifo_valid;
    logic fifo_ready;
    logic [9:0] fifo_data;
    rx_state_t rx_state_reg;
    rx_state_t rx_state_next;
    logic [10:0] rx_count_reg;
    logic [7:0] rx_lo_reg;
    logic rx_err_reg;
    logic rx_long_reg;
    logic [RXA-1:0] rx_rd_ptr_reg;
    logic dma_open_d_reg;
    logic rx_read_seen_reg;

    stream_fifo #(
        .WIDTH(10),
        .DEPTH(queue_access_pkg::FIFO_DEPTH)
    ) stream_fifo_inst (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data({rx_last, rx_error, rx_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    wire rx_enable = rx_control_one_reg[queue_access_pkg::BIT_RXC1_RX_ENABLE]; // [R12]
    wire f_last = fifo_data[9];
    wire f_err = fifo_data[8];
    wire [7:0] f_byte = fifo_data[7:0];
    // A disabled receiver in idle drains the FIFO so the MAC never stalls forever.
    assign fifo_ready = (rx_state_reg == RX_DATA) || ((rx_state_reg == RX_IDLE) && !rx_enable);
    wire rx_take = fifo_valid && fifo_ready && (rx_state_reg == RX_DATA);
    wire rx_fits = (rx_count_reg < queue_access_pkg::RX_MAX_DATA_BYTES); // [R10]
    wire [RXA-1:0] rx_byte_word = RXA'(rx_count_reg[10:1]) + RXA'(queue_access_pkg::DATA_WORD_FIRST); // [R9]
    wire rx_word_wr = rx_take && rx_fits && (rx_count_reg[0] || f_last);
    wire [15:0] rx_word_data = rx_count_reg[0] ? {f_byte, rx_lo_reg} : {8'h00, f_byte};
    wire [15:0] rx_status_word = {1'b1, 12'h000, rx_long_reg, 1'b0, rx_err_reg}; // [R7]
    wire [10:0] rx_stored = rx_long_reg ? queue_access_pkg::RX_MAX_DATA_BYTES : rx_count_reg;
    // Host releases the frame by closing the window after reading from it.
    wire rx_release = (rx_state_reg == RX_HOLD) && dma_open_d_reg && !dma_open && rx_read_seen_reg;

    always_comb begin
        rx_state_next = rx_state_reg;
        unique case (rx_state_reg)
            RX_IDLE: begin
                if (fifo_valid && rx_enable) begin
                    rx_state_next = RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_take && f_last) begin
                    rx_state_next = RX_HDR0;
                end
            end
            RX_HDR0: rx_state_next = RX_HDR1;
            RX_HDR1: rx_state_next = RX_HOLD;
            RX_HOLD: begin
                if (rx_release) begin
                    rx_state_next = RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_state_reg <= RX_IDLE;
            rx_count_reg <= '0;
            rx_lo_reg <= '0;
            rx_err_reg <= 1'b0;
            rx_long_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            if (rx_state_reg == RX_IDLE) begin
                rx_count_reg <= '0;
                rx_err_reg <= 1'b0;
                rx_long_reg <= 1'b0;
            end else if (rx_take) begin
                rx_lo_reg <= f_byte;
                rx_err_reg <= rx_err_reg | f_err;
                rx_long_reg <= rx_long_reg | !rx_fits; // [R10]
                if (rx_fits) begin
                    rx_count_reg <= rx_count_reg + 11'd1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rx_word_wr) begin
            rx_mem[rx_byte_word] <= rx_word_data; // [R9]
        end else if (rx_state_reg == RX_HDR0) begin
            rx_mem[queue_access_pkg::HDR_WORD_STATUS] <= rx_status_word; // [R7]
        end else if (rx_state_reg == RX_HDR1) begin
            rx_mem[queue_access_pkg::HDR_WORD_COUNT] <= {5'h00, rx_stored}; // [R8]
        end
    end

    // The read pointer restarts at the frame head when the window opens.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_rd_ptr_reg <= '0;
            dma_open_d_reg <= 1'b0;
            rx_read_seen_reg <= 1'b0;
        end else begin
            dma_open_d_reg <= dma_open;
            if (dma_open && !dma_open_d_reg) begin
                rx_rd_ptr_reg <= '0;
                rx_read_seen_reg <= 1'b0;
            end else if (data_rd) begin
                rx_rd_ptr_reg <= rx_rd_ptr_reg + 1'b1;
                rx_read_seen_reg <= (rx_state_reg == RX_HOLD);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit path: host writes, engine streams the queued frame.
    tx_state_t tx_state_reg;
    tx_state_t tx_state_next;
    logic [TXA-1:0] tx_idx_reg;
    logic [10:0] tx_bc_reg;
    wire [TXA-1:0] tx_wr_word = TXA'(tx_data_ptr_reg[queue_access_pkg::PTR_MSB:1]);
    wire [1:0] data_lanes = {1'b0, bus_be[0]} + {1'b0, bus_be[1]};
    wire [10:0] tx_ptr_step = {9'h000, data_lanes};
    wire [10:0] tx_bc_now = tx_mem[queue_access_pkg::HDR_WORD_COUNT][10:0];
    wire [TXA-1:0] tx_words = (tx_bc_reg == 11'd0) ? TXA'(1) : TXA'((tx_bc_reg + 11'd1) >> 1);
    wire tx_load = (tx_state_reg == TX_SEND) && (!tx_valid || tx_ready) && (tx_idx_reg != tx_words);
    wire tx_end = tx_valid && tx_ready && tx_last;
    wire tx_queued = tx_queue_cmd_reg[queue_access_pkg::BIT_TXQ_ENQUEUE];
    wire [16:0] tx_used_dw = tx_queued ? 17'((tx_bc_reg + 11'd7) >> 2) : 17'h0_0000;
    wire [16:0] tx_free_dw = TX_DWORDS - tx_used_dw; // [R6]
    wire space_ok = tx_queue_cmd_reg[queue_access_pkg::BIT_TXQ_SPACE_ARM]
        && (tx_free_dw >= {1'b0, tx_space_req_reg}); // [R14]
    wire tx_done_evt = (tx_state_reg == TX_DONE);

    always_comb begin
        tx_state_next = tx_state_reg;
        unique case (tx_state_reg)
            TX_IDLE: begin
                if (tx_queued) begin
                    tx_state_next = TX_SEND;
                end
            end
            TX_SEND: begin
                if (tx_end) begin
                    tx_state_next = TX_DONE;
                end
            end
            TX_DONE: tx_state_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_state_reg <= TX_IDLE;
            tx_idx_reg <= '0;
            tx_bc_reg <= '0;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            tx_data <= '0;
        end else begin
            tx_state_reg <= tx_state_next;
            if (tx_state_reg == TX_IDLE) begin
                tx_idx_reg <= '0;
                tx_bc_reg <= tx_bc_now;
            end
            if (tx_load) begin
                tx_data <= tx_mem[TXA'(queue_access_pkg::DATA_WORD_FIRST) + tx_idx_reg];
                tx_last <= (tx_idx_reg == tx_words - 1'b1);
                tx_valid <= 1'b1;
                tx_idx_reg <= tx_idx_reg + 1'b1;
            end else if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (data_wr) begin
            tx_mem[tx_wr_word] <= (tx_mem[tx_wr_word] & ~be_mask) | (bus_wdata & be_mask); // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes.
    wire ptr_auto = tx_data_ptr_reg[queue_access_pkg::BIT_TXPTR_AUTO_INC];
    wire [15:0] ptr_advanced = {tx_data_ptr_reg[15:11], tx_data_ptr_reg[10:0] + tx_ptr_step};
    wire [15:0] int_set = (16'(tx_done_evt) << queue_access_pkg::BIT_INT_TX_DONE)
        | (16'(space_ok) << queue_access_pkg::BIT_INT_TX_SPACE)
        | (16'(rx_state_reg == RX_HDR1) << queue_access_pkg::BIT_INT_RX_FRAME);
    wire [15:0] txq_clear = (16'(tx_done_evt) << queue_access_pkg::BIT_TXQ_ENQUEUE)
        | (16'(space_ok) << queue_access_pkg::BIT_TXQ_SPACE_ARM);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_control_one_reg <= queue_access_pkg::RST_REG;
            rx_queue_cmd_reg <= queue_access_pkg::RST_REG;
            tx_queue_cmd_reg <= queue_access_pkg::RST_REG;
            tx_data_ptr_reg <= queue_access_pkg::RST_REG;
            int_enable_reg <= queue_access_pkg::RST_REG;
            int_status_reg <= queue_access_pkg::RST_REG;
            tx_space_req_reg <= queue_access_pkg::RST_REG;
        end else begin
            if (bus_wr && sel_rxc1) begin
                rx_control_one_reg <= wmerge_rxc1; // [R12]
            end
            if (bus_wr && sel_rxq_cmd) begin
                rx_queue_cmd_reg <= wmerge_rxq & queue_access_pkg::MASK_RX_QUEUE_CMD; // [R1]
            end
            if (bus_wr && sel_txptr) begin
                tx_data_ptr_reg <= wmerge_ptr & queue_access_pkg::MASK_TX_DATA_PTR;
            end else if (data_wr && ptr_auto) begin
                tx_data_ptr_reg <= ptr_advanced; // [R2]
            end
            if (bus_wr && sel_ier) begin
                int_enable_reg <= wmerge_ier;
            end
            if (bus_wr && sel_space) begin
                tx_space_req_reg <= wmerge_space; // [R6]
            end
            // A new event wins over a clear in the same cycle.
            int_status_reg <= ((int_status_reg & ~isr_clear) | int_set)
                & queue_access_pkg::MASK_INT_STATUS; // [R5]
            // Host writes of one set the bits; completion clears them.
            tx_queue_cmd_reg <= ((tx_queue_cmd_reg & ~txq_clear) | txq_set)
                & queue_access_pkg::MASK_TX_QUEUE_CMD; // [R13] [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and interrupt.
    wire [15:0] rx_word_raw = rx_mem[rx_rd_ptr_reg];
    wire rx_hdr_word = (rx_rd_ptr_reg < RXA'(queue_access_pkg::DATA_WORD_FIRST));
    wire [15:0] rx_word_out = (be_sync2_reg && rx_hdr_word)
        ? {rx_word_raw[7:0], rx_word_raw[15:8]} : rx_word_raw; // [R11]
    wire [15:0] rd_mux = sel_txq_cmd ? tx_queue_cmd_reg
        : sel_rxc1 ? rx_control_one_reg
        : sel_rxq_cmd ? rx_queue_cmd_reg
        : sel_txptr ? tx_data_ptr_reg
        : sel_ier ? int_enable_reg
        : sel_isr ? int_status_reg
        : sel_space ? tx_space_req_reg
        : data_rd ? rx_word_out
        : 16'h0000;
    wire irq_any = |(int_status_reg & int_enable_reg); // [R3] [R4] [R15]

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_rdata <= '0;
            bus_rvalid <= 1'b0;
            irq_n <= 1'b1;
            rx_flow_ctrl_en <= 1'b0;
        end else begin
            bus_rvalid <= bus_rd;
            if (bus_rd) begin
                bus_rdata <= rd_mux & be_mask;
            end
            irq_n <= !irq_any; // [R15]
            rx_flow_ctrl_en <= rx_control_one_reg[queue_access_pkg::BIT_RXC1_FLOW_CTRL]; // [R12]
        end
    end
endmodule

// >>> include/queue_access_pkg.sv
// Purpose: Shared constants for the queue access block.
// Assumes: 16-bit register port.
// Notes: Offsets are byte addresses.
package queue_access_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] OFF_TX_QUEUE_CMD = 8'h80;
    localparam logic [7:0] OFF_RX_CONTROL_ONE = 8'h74;
    localparam logic [7:0] OFF_RX_QUEUE_CMD = 8'h82;
    localparam logic [7:0] OFF_TX_DATA_PTR = 8'h84;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h90;
    localparam logic [7:0] OFF_INT_STATUS = 8'h92;
    localparam logic [7:0] OFF_TX_SPACE_REQ = 8'h9e;
    localparam logic [7:0] OFF_QUEUE_DATA = 8'hc0;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int BIT_TXQ_ENQUEUE = 0;
    localparam int BIT_TXQ_SPACE_ARM = 1;
    localparam int BIT_RXQ_DMA_START = 3;
    localparam int BIT_TXPTR_AUTO_INC = 14;
    localparam int BIT_INT_TX_DONE = 14;
    localparam int BIT_INT_RX_FRAME = 13;
    localparam int BIT_INT_TX_SPACE = 6;
    localparam int BIT_RXC1_FLOW_CTRL = 10;
    localparam int BIT_RXC1_RX_ENABLE = 0;
    localparam int BIT_RXST_VALID = 15;
    localparam int BIT_RXST_TOO_LONG = 2;
    localparam int BIT_RXST_ERROR = 0;
    localparam int PTR_MSB = 10;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and masks.
    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [15:0] MASK_INT_STATUS = 16'h6040;
    localparam logic [15:0] MASK_TX_DATA_PTR = 16'h47ff;
    localparam logic [15:0] MASK_RX_QUEUE_CMD = 16'h0008;
    localparam logic [15:0] MASK_TX_QUEUE_CMD = 16'h0003;

    ////////////////////////////////////////////////////////////////////////
    // Frame layout, in bytes and words.
    localparam logic [10:0] RX_MAX_DATA_BYTES = 11'd2000;
    localparam int HDR_WORD_STATUS = 0;
    localparam int HDR_WORD_COUNT = 1;
    localparam int DATA_WORD_FIRST = 2;
    localparam int FIFO_DEPTH = 4;

endpackage

// >>> verilog/stream_fifo.sv
// Purpose: Small valid/ready FIFO.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full and empty are exact; no bypass path.
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_reg];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> tb/queue_access_assertions.sv
// Purpose: Port checks.
// Assumes: Synchronous active-high reset on clk_sys.
// Notes: Bound into the design.
`timescale 1ns/1ps
module queue_access_assertions #(
    parameter int RX_WORDS = 1024,
    parameter int TX_WORDS = 1024
) (
    // Clock and reset.
    input logic clk_sys,
    input logic reset,
    // Host command port.
    input logic [7:0] bus_addr,
    input logic bus_wr,
    input logic bus_rd,
    input logic [1:0] bus_be,
    input logic [15:0] bus_wdata,
    input logic [15:0] bus_rdata,
    input logic bus_rvalid,
    input logic big_endian_pin,
    // Streams and status.
    input logic rx_valid,
    input logic rx_ready,
    input logic [7:0] rx_data,
    input logic rx_last,
    input logic rx_error,
    input logic tx_valid,
    input logic tx_ready,
    input logic [15:0] tx_data,
    input logic tx_last,
    input logic irq_n,
    input logic rx_flow_ctrl_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff reset;
    wire map_hit = bus_addr inside {8'h74, 8'h80, 8'h82, 8'h84, 8'h90, 8'h92, 8'h9e, 8'hc0};
    ////////////////////////////////////////////////////////////
    read_answer_a: assert property (bus_rd |=> bus_rvalid)
        else $error("read unanswered");
    no_spurious_a: assert property (!bus_rd |=> !bus_rvalid)
        else $error("answer without read");
    unmapped_zero_a: assert property (bus_rd && !map_hit |=> bus_rdata == 16'h0000)
        else $error("unmapped read");
    lane_mask_a: assert property (bus_rd && bus_be == 2'h0 |=> bus_rdata == 16'h0000)
        else $error("masked lanes");
    flow_ctrl_a: assert property (bus_wr && bus_addr == 8'h74 && bus_be[1]
        |=> ##[0:1] rx_flow_ctrl_en == $past(bus_wdata[10], 2) || rx_flow_ctrl_en == $past(bus_wdata[10]))
        else $error("flow control mismatch");
    irq_mask_off_a: assert property (bus_wr && bus_addr == 8'h90 && bus_be == 2'h3
        && bus_wdata == 16'h0000 |=> ##1 irq_n)
        else $error("request with enables off");
    irq_reset_a: assert property (disable iff (1'b0) reset |=> irq_n && !rx_flow_ctrl_en)
        else $error("outputs active in reset");
    stream_reset_a: assert property (disable iff (1'b0) reset |=> !tx_valid && rx_ready && !bus_rvalid)
        else $error("stream busy in reset");
    tx_hold_a: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("stalled word changed");
endmodule

bind host_queue_frame_access queue_access_assertions #(.RX_WORDS(RX_WORDS), .TX_WORDS(TX_WORDS)) chk_inst (
    .clk_sys, .reset, .bus_addr, .bus_wr, .bus_rd, .bus_be, .bus_wdata, .bus_rdata, .bus_rvalid,
    .big_endian_pin, .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_error, .tx_valid, .tx_ready,
    .tx_data, .tx_last, .irq_n, .rx_flow_ctrl_en);

// >>> tb/host_bus_model.sv
// Purpose: Host processor model on the register port.
// Assumes: Strobes change on the falling edge.
// Notes: One access every two cycles.
`timescale 1ns/1ps
module host_bus_model (
    // Clock.
    input logic clk_sys,
    // Register port.
    output logic [7:0] bus_addr = 8'h00,
    output logic bus_wr = 1'b0,
    output logic bus_rd = 1'b0,
    output logic [1:0] bus_be = 2'h0,
    output logic [15:0] bus_wdata = 16'h0000,
    input logic [15:0] bus_rdata,
    input logic bus_rvalid
);
    ////////////////////////////////////////////////////////////
    // Released write data is inverted so a stale value never looks fresh.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        bus_addr = a;
        bus_wdata = d;
        bus_be = 2'h3;
        bus_wr = 1'b1;
        @(negedge clk_sys);
        bus_wr = 1'b0;
        bus_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        bus_addr = a;
        bus_be = 2'h3;
        bus_rd = 1'b1;
        @(negedge clk_sys);
        bus_rd = 1'b0;
        d = bus_rvalid ? bus_rdata : 16'hdead;
    endtask
endmodule

// >>> tb/host_queue_frame_access_tb.sv
// Purpose: Self-checking bench.
// Assumes: Inputs change on the falling edge.
// Notes: Each scenario is one task.
`timescale 1ns/1ps
module host_queue_frame_access_tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    wire [7:0] bus_addr;
    wire bus_wr, bus_rd;
    wire [1:0] bus_be;
    wire [15:0] bus_wdata;
    logic [15:0] bus_rdata, tx_data;
    logic bus_rvalid, rx_ready, tx_valid, tx_last, irq_n, rx_flow_ctrl_en;
    logic big_endian_pin = 1'b0, rx_valid = 1'b0, rx_last = 1'b0, rx_error = 1'b0, tx_ready = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic [15:0] txw[$];
    int miscompares = 0, cmp_count = 0, cycles = 0;
    always #4 clk_sys = ~clk_sys;
    host_queue_frame_access host_queue_frame_access_inst (.clk_sys, .reset, .bus_addr, .bus_wr, .bus_rd,
        .bus_be, .bus_wdata, .bus_rdata, .bus_rvalid, .big_endian_pin, .rx_valid, .rx_ready, .rx_data,
        .rx_last, .rx_error, .tx_valid, .tx_ready, .tx_data, .tx_last, .irq_n, .rx_flow_ctrl_en);
    host_bus_model host_bus_model_inst (.clk_sys, .bus_addr, .bus_wr, .bus_rd, .bus_be, .bus_wdata,
        .bus_rdata, .bus_rvalid);
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) begin
            txw.push_back(tx_data);
        end
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host_bus_model_inst.rd(a, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host_bus_model_inst.wr(a, d);
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 100 && irq_n !== 1'b0; i++) @(negedge clk_sys);
    endtask
    task automatic test_regs;
        chk(16'(irq_n), 16'h0001);
        rdchk(8'h90, 16'h0000);
        rdchk(8'h92, 16'h0000);
        wr(8'h74, 16'h0401);
        rdchk(8'h74, 16'h0401);
        chk(16'(rx_flow_ctrl_en), 16'h0001);
        wr(8'h9e, 16'ha5c3);
        rdchk(8'h9e, 16'ha5c3);
        rdchk(8'h10, 16'h0000);
        rdchk(8'hc0, 16'h0000);
        $display("test_regs done");
    endtask
    task automatic test_rx;
        logic [7:0] b[5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        big_endian_pin = 1'b1;
        wr(8'h90, 16'h2000);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_sys);
            rx_valid = 1'b1;
            rx_data = b[i];
            rx_last = (i == 4);
            rx_error = (i == 2);
            while (!rx_ready) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_data = ~rx_data;
        wait_irq();
        chk(16'(irq_n), 16'h0000);
        rdchk(8'h92, 16'h2000);
        wr(8'h92, 16'hffff);
        wr(8'h82, 16'h0008);
        rdchk(8'hc0, 16'h0180);
        rdchk(8'hc0, 16'h0500);
        rdchk(8'hc0, 16'h2211);
        rdchk(8'hc0, 16'h4433);
        wr(8'h82, 16'h0000);
        big_endian_pin = 1'b0;
        $display("test_rx done");
    endtask
    task automatic test_tx;
        logic [15:0] w[4] = '{16'h0000, 16'h0004, 16'hbbaa, 16'hddcc};
        wr(8'h82, 16'h0008);
        wr(8'h84, 16'h4000);
        foreach (w[i]) wr(8'hc0, w[i]);
        rdchk(8'h84, 16'h4008);
        wr(8'h82, 16'h0000);
        wr(8'h90, 16'h4000);
        wr(8'h80, 16'h0001);
        repeat (4) @(negedge clk_sys);
        tx_ready = 1'b1;
        wait_irq();
        chk(16'(irq_n), 16'h0000);
        chk(16'(txw.size()), 16'h0002);
        chk(txw[0], 16'hbbaa);
        chk(txw[1], 16'hddcc);
        rdchk(8'h80, 16'h0000);
        rdchk(8'h92, 16'h4000);
        wr(8'h92, 16'hffff);
        repeat (3) @(negedge clk_sys);
        chk(16'(irq_n), 16'h0001);
        $display("test_tx done");
    endtask
    task automatic test_space;
        wr(8'h90, 16'h0040);
        wr(8'h9e, 16'h0001);
        wr(8'h80, 16'h0002);
        wait_irq();
        chk(16'(irq_n), 16'h0000);
        rdchk(8'h92, 16'h0040);
        rdchk(8'h80, 16'h0000);
        wr(8'h90, 16'h0000);
        repeat (3) @(negedge clk_sys);
        chk(16'(irq_n), 16'h0001);
        wr(8'h92, 16'hffff);
        $display("test_space done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        test_regs();
        test_rx();
        test_tx();
        test_space();
        report_and_stop();
    end
endmodule
